// ===== src/idm_io_mapper.sv
// Digital input debouncing, status word and mask-mapped digital outputs
`include "idm_params.svh"

// Function
// - Without inversion, output is 1 when selected bit set, else 0.
// - With inversion set, a clear selected bit gives 1, set gives 0.
// - Output one resets to field 1544 with mask 0x80.
// - Output two resets to field 1132 with mask 0xD.
// - Output three resets to a zero mask, so it stays inactive.
// - Each output has read/write 16-bit field number and 32-bit mask.
// - Output is 1 when any masked bit of the source is set.
// - Each input has 8-bit settle count, default 1, at most 254.
// - Inputs sampled every 2 ms; change accepted after settle-count equal samples.
// - Each input has invert setting 0 or 1, default 0, flipping handler sense.
// - Each input has 8-bit handler select, default 0.
// - Hardware-enable input has its own independent set of settings.
// - Read-only 8-bit input status word, also offered for cyclic transfer.
// - Status bit 0 is input one, bit 7 eighth input, ignoring invert.
module idm_io_mapper
	import idm_pkg::*;
#(
	parameter int SAMPLE_CYCLES = `IDM_SAMPLE_CYCLES
) (
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	input wire logic [7:0] DIN_IN,
	input wire logic OD_RD_IN,
	input wire logic OD_WR_IN,
	input wire idm_pkg::idm_field_t OD_INDEX_IN,
	input wire idm_pkg::idm_byte_t OD_SUB_IN,
	input wire idm_pkg::idm_word_t OD_WDATA_IN,
	output idm_pkg::idm_word_t OD_RDATA_OUT,
	output logic OD_ACK_OUT,
	output logic OD_ERR_OUT,
	input wire idm_pkg::idm_word_t PARAM1_VALUE_IN,
	input wire idm_pkg::idm_word_t PARAM2_VALUE_IN,
	input wire idm_pkg::idm_word_t PARAM3_VALUE_IN,
	output idm_pkg::idm_field_t SRC1_FIELD_OUT,
	output idm_pkg::idm_field_t SRC2_FIELD_OUT,
	output idm_pkg::idm_field_t SRC3_FIELD_OUT,
	output logic [2:0] DOUT_OUT,
	output logic [7:0] HANDLER_ACTIVE_OUT,
	output idm_pkg::idm_byte_t STATUS_WORD_OUT
);
	import idm_pkg::*;

	localparam int TICK_W = $clog2(SAMPLE_CYCLES + 1);

	// Sub-index of a per-input setting; the hardware-enable input owns slot 0
	function automatic idm_byte_t cfg_sub(input int pin, input int ofs);
		int slot;
		slot = (pin == `IDM_SLOT_HWEN_PIN) ? 0 : pin + 1;
		return 8'(slot * `IDM_SUBS_PER_SLOT + ofs);
	endfunction

	function automatic idm_byte_t ctrl_sub(input int pin);
		int slot;
		slot = (pin == `IDM_SLOT_HWEN_PIN) ? 0 : pin + 1;
		return 8'(int'(`IDM_SUB_CTRL_BASE) + slot);
	endfunction

	// ***************************************************************
	// Sample tick
	// ***************************************************************
	logic [TICK_W-1:0] div_reg;
	logic [TICK_W-1:0] div_next;
	logic tick_reg;
	logic tick_next;

	always_comb begin
		tick_next = 1'b0;
		div_next = div_reg + 1'b1;
		if (div_reg == TICK_W'(SAMPLE_CYCLES - 1)) begin
			div_next = '0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			tick_reg <= tick_next;
		end
	end

	// ***************************************************************
	// Settings
	// ***************************************************************
	idm_byte_t select_reg [8];
	idm_byte_t select_next [8];
	idm_byte_t settle_reg [8];
	idm_byte_t settle_next [8];
	idm_byte_t iflip_reg [8];
	idm_byte_t iflip_next [8];
	idm_byte_t ctrl_reg [8];
	idm_byte_t ctrl_next [8];
	idm_field_t field_reg [3];
	idm_field_t field_next [3];
	idm_word_t mask_reg [3];
	idm_word_t mask_next [3];
	idm_byte_t oflip_reg [3];
	idm_byte_t oflip_next [3];
	idm_word_t rdata_reg;
	idm_word_t rdata_next;
	idm_acc_e acc_reg;
	idm_acc_e acc_next;
	logic [7:0] level;
	logic hit;
	logic bad;
	logic req;
	idm_word_t rval;

	always_comb begin
		select_next = select_reg;
		settle_next = settle_reg;
		iflip_next = iflip_reg;
		ctrl_next = ctrl_reg;
		field_next = field_reg;
		mask_next = mask_reg;
		oflip_next = oflip_reg;
		rdata_next = rdata_reg;
		hit = 1'b0;
		bad = 1'b0;
		rval = '0;
		req = OD_RD_IN | OD_WR_IN;
		if (OD_INDEX_IN == `IDM_IDX_INPUTS) begin
			for (int p = 0; p < 8; p++) begin
				if (OD_SUB_IN == cfg_sub(p, `IDM_SUB_OFS_SELECT)) begin
					hit = 1'b1;
					rval = {24'h000000, select_reg[p]};
					if (OD_WR_IN) begin
						select_next[p] = OD_WDATA_IN[7:0];
					end
				end
				if (OD_SUB_IN == cfg_sub(p, `IDM_SUB_OFS_SETTLE)) begin
					hit = 1'b1;
					rval = {24'h000000, settle_reg[p]};
					if (OD_WR_IN && (OD_WDATA_IN > `IDM_SETTLE_MAX)) begin
						bad = 1'b1;
					end else if (OD_WR_IN) begin
						settle_next[p] = OD_WDATA_IN[7:0];
					end
				end
				if (OD_SUB_IN == cfg_sub(p, `IDM_SUB_OFS_FLIP)) begin
					hit = 1'b1;
					rval = {24'h000000, iflip_reg[p]};
					if (OD_WR_IN && (OD_WDATA_IN > `IDM_FLIP_MAX)) begin
						bad = 1'b1;
					end else if (OD_WR_IN) begin
						iflip_next[p] = OD_WDATA_IN[7:0];
					end
				end
				if (OD_SUB_IN == ctrl_sub(p)) begin
					hit = 1'b1;
					rval = {24'h000000, ctrl_reg[p]};
					if (OD_WR_IN) begin
						ctrl_next[p] = OD_WDATA_IN[7:0];
					end
				end
			end
		end else if (OD_INDEX_IN == `IDM_IDX_STATUS) begin
			if (OD_SUB_IN == `IDM_SUB_STATUS) begin
				hit = 1'b1;
				rval = {24'h000000, level};
				bad = OD_WR_IN;
			end
		end else if (OD_INDEX_IN == `IDM_IDX_OUTPUTS) begin
			for (int j = 0; j < 3; j++) begin
				if (OD_SUB_IN == 8'(j * 3 + 1)) begin
					hit = 1'b1;
					rval = {16'h0000, field_reg[j]};
					if (OD_WR_IN) begin
						field_next[j] = OD_WDATA_IN[15:0];
					end
				end
				if (OD_SUB_IN == 8'(j * 3 + 2)) begin
					hit = 1'b1;
					rval = mask_reg[j];
					if (OD_WR_IN) begin
						mask_next[j] = OD_WDATA_IN;
					end
				end
				if (OD_SUB_IN == 8'(j * 3 + 3)) begin
					hit = 1'b1;
					rval = {24'h000000, oflip_reg[j]};
					if (OD_WR_IN && (OD_WDATA_IN > `IDM_FLIP_MAX)) begin
						bad = 1'b1;
					end else if (OD_WR_IN) begin
						oflip_next[j] = OD_WDATA_IN[7:0];
					end
				end
			end
		end
		// Read wins if both strobes arrive; a write is still applied
		if (OD_RD_IN && hit) begin
			rdata_next = rval;
		end
		if (!req) begin
			acc_next = IDM_ACC_NONE;
		end else if (hit && !bad) begin
			acc_next = IDM_ACC_OK;
		end else begin
			acc_next = IDM_ACC_ERR;
		end
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			for (int p = 0; p < 8; p++) begin
				select_reg[p] <= `IDM_SELECT_RST;
				settle_reg[p] <= `IDM_SETTLE_RST;
				iflip_reg[p] <= `IDM_FLIP_RST;
				ctrl_reg[p] <= `IDM_CTRL_RST;
			end
			field_reg[0] <= `IDM_OUT1_FIELD_RST;
			mask_reg[0] <= `IDM_OUT1_MASK_RST;
			field_reg[1] <= `IDM_OUT2_FIELD_RST;
			mask_reg[1] <= `IDM_OUT2_MASK_RST;
			field_reg[2] <= `IDM_OUT3_FIELD_RST;
			mask_reg[2] <= `IDM_OUT3_MASK_RST;
			for (int j = 0; j < 3; j++) begin
				oflip_reg[j] <= `IDM_FLIP_RST;
			end
			rdata_reg <= '0;
			acc_reg <= IDM_ACC_NONE;
		end else begin
			select_reg <= select_next;
			settle_reg <= settle_next;
			iflip_reg <= iflip_next;
			ctrl_reg <= ctrl_next;
			field_reg <= field_next;
			mask_reg <= mask_next;
			oflip_reg <= oflip_next;
			rdata_reg <= rdata_next;
			acc_reg <= acc_next;
		end
	end

	// ***************************************************************
	// Inputs
	// ***************************************************************
	for (genvar p = 0; p < 8; p++) begin : g_in
		idm_debounce u_deb (
			.clk_in(CLK_IN),
			.reset_in(RESET_IN),
			.pin_in(DIN_IN[p]),
			.tick_in(tick_reg),
			.settle_in(settle_reg[p]),
			.level_out(level[p])
		);
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	logic [2:0] dout_reg;
	logic [2:0] dout_next;
	logic [7:0] handler_reg;
	logic [7:0] handler_next;
	idm_word_t param [3];

	always_comb begin
		param[0] = PARAM1_VALUE_IN;
		param[1] = PARAM2_VALUE_IN;
		param[2] = PARAM3_VALUE_IN;
		dout_next = dout_reg;
		for (int j = 0; j < 3; j++) begin
			if (tick_reg) begin
				dout_next[j] = (|(param[j] & mask_reg[j])) ^ oflip_reg[j][0];
			end
		end
		for (int p = 0; p < 8; p++) begin
			handler_next[p] = level[p] ^ iflip_reg[p][0];
		end
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			dout_reg <= 3'h0;
			handler_reg <= 8'h00;
		end else begin
			dout_reg <= dout_next;
			handler_reg <= handler_next;
		end
	end

	assign DOUT_OUT = dout_reg;
	assign HANDLER_ACTIVE_OUT = handler_reg;
	assign STATUS_WORD_OUT = level;
	assign SRC1_FIELD_OUT = field_reg[0];
	assign SRC2_FIELD_OUT = field_reg[1];
	assign SRC3_FIELD_OUT = field_reg[2];
	assign OD_RDATA_OUT = rdata_reg;
	assign OD_ACK_OUT = (acc_reg == IDM_ACC_OK);
	assign OD_ERR_OUT = (acc_reg == IDM_ACC_ERR);

	// ***************************************************************
	// Checks
	// ***************************************************************
	out_map_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		tick_reg |=> DOUT_OUT[0] == ((|($past(PARAM1_VALUE_IN) & $past(mask_reg[0]))) ^ $past(oflip_reg[0][0])))
		else $error("output one does not follow masked source");
	out_flip_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		tick_reg && oflip_reg[1][0] && |(PARAM2_VALUE_IN & mask_reg[1]) |=> !DOUT_OUT[1])
		else $error("inverted output two not cleared");
	out_hold_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		!tick_reg |=> $stable(DOUT_OUT))
		else $error("outputs changed off the sample tick");
	tick_space_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		tick_reg |=> !tick_reg [*2])
		else $error("sample ticks too close");
	settle_range_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		OD_WR_IN && (OD_INDEX_IN == `IDM_IDX_INPUTS) && (OD_SUB_IN == 8'h02) && (OD_WDATA_IN > `IDM_SETTLE_MAX)
		|=> OD_ERR_OUT && $stable(settle_reg[7]))
		else $error("out of range settle count accepted");
	flip_range_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		iflip_reg[0] <= 8'h01 && oflip_reg[2] <= 8'h01)
		else $error("invert setting beyond one");
	status_raw_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		OD_RD_IN && (OD_INDEX_IN == `IDM_IDX_STATUS) && (OD_SUB_IN == `IDM_SUB_STATUS)
		|=> OD_ACK_OUT && (OD_RDATA_OUT == {24'h000000, $past(level)}))
		else $error("status word read wrong");
	status_ro_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		OD_WR_IN && (OD_INDEX_IN == `IDM_IDX_STATUS) |=> OD_ERR_OUT && !OD_ACK_OUT)
		else $error("status word write not refused");
	answer_once_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		(OD_RD_IN || OD_WR_IN) |=> (OD_ACK_OUT ^ OD_ERR_OUT))
		else $error("request without single answer");
	cover_out_c: cover property (@(posedge CLK_IN) disable iff (RESET_IN) tick_reg ##1 $rose(DOUT_OUT[0]));
	cover_err_c: cover property (@(posedge CLK_IN) disable iff (RESET_IN) OD_ERR_OUT);
	cover_mask_c: cover property (@(posedge CLK_IN) disable iff (RESET_IN) OD_WR_IN ##1 OD_ACK_OUT ##1 tick_reg);

endmodule // idm_io_mapper

// ===== include/idm_params.svh
// Offsets, field positions, reset values and timing counts of the digital I/O mapper
`ifndef IDM_PARAMS_SVH
`define IDM_PARAMS_SVH

// ***************************************************************
// Timing
// ***************************************************************
`define IDM_CLK_FREQ_KHZ 40000
`define IDM_SAMPLE_PERIOD_US 2000
`define IDM_SAMPLE_CYCLES ((`IDM_SAMPLE_PERIOD_US * `IDM_CLK_FREQ_KHZ) / 1000)

// ***************************************************************
// Object dictionary indices and sub-indices
// ***************************************************************
`define IDM_IDX_OUTPUTS 16'h2C2C
`define IDM_IDX_STATUS 16'h2C2D
`define IDM_IDX_INPUTS 16'h2C2E
`define IDM_SUB_STATUS 8'h01
`define IDM_SUB_CTRL_BASE 8'h19
`define IDM_SUBS_PER_SLOT 3
`define IDM_SUB_OFS_SELECT 1
`define IDM_SUB_OFS_SETTLE 2
`define IDM_SUB_OFS_FLIP 3
`define IDM_SLOT_HWEN_PIN 7

// ***************************************************************
// Reset values and limits
// ***************************************************************
`define IDM_SELECT_RST 8'h00
`define IDM_SETTLE_RST 8'h01
`define IDM_SETTLE_MAX 32'h000000FE
`define IDM_FLIP_RST 8'h00
`define IDM_FLIP_MAX 32'h00000001
`define IDM_CTRL_RST 8'h00
`define IDM_OUT1_FIELD_RST 16'h0608
`define IDM_OUT1_MASK_RST 32'h00000080
`define IDM_OUT2_FIELD_RST 16'h046C
`define IDM_OUT2_MASK_RST 32'h0000000D
`define IDM_OUT3_FIELD_RST 16'h0606
`define IDM_OUT3_MASK_RST 32'h00000000

`endif

// ===== include/idm_pkg.sv
// Types shared by the digital I/O mapper design files
package idm_pkg;
	typedef logic [7:0] idm_byte_t;
	typedef logic [15:0] idm_field_t;
	typedef logic [31:0] idm_word_t;
	typedef enum logic [1:0] {
		IDM_ACC_NONE = 2'b00,
		IDM_ACC_OK = 2'b01,
		IDM_ACC_ERR = 2'b10
	} idm_acc_e;
endpackage : idm_pkg

// ===== src/idm_debounce.sv
// One input channel: pin synchroniser and tick-based settle filter
module idm_debounce
	import idm_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic pin_in,
	input wire logic tick_in,
	input wire idm_pkg::idm_byte_t settle_in,
	output logic level_out
);
	import idm_pkg::*;

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic level_reg;
	logic level_next;
	idm_byte_t cnt_reg;
	idm_byte_t cnt_next;
	logic [8:0] cnt_inc;
	logic [8:0] need;

	// ***************************************************************
	// Settle filter
	// ***************************************************************
	always_comb begin
		level_next = level_reg;
		cnt_next = cnt_reg;
		cnt_inc = {1'b0, cnt_reg} + 9'h001;
		// Zero behaves as one so the input can never lock up
		need = (settle_in == 8'h00) ? 9'h001 : {1'b0, settle_in};
		if (tick_in) begin
			if ((s2_reg == s3_reg) && (s3_reg != level_reg)) begin
				if (cnt_inc >= need) begin
					level_next = s3_reg;
					cnt_next = 8'h00;
				end else begin
					cnt_next = cnt_inc[7:0];
				end
			end else begin
				cnt_next = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_reg <= 1'b0;
			cnt_reg <= 8'h00;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
			cnt_reg <= cnt_next;
		end
	end

	assign level_out = level_reg;

	// ***************************************************************
	// Checks
	// ***************************************************************
	level_on_tick_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(level_reg != $past(level_reg)) |-> $past(tick_in))
		else $error("input level changed off the sample tick");
	level_settled_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(level_reg != $past(level_reg)) |-> (level_reg == $past(s3_reg)) && ($past(s2_reg) == $past(s3_reg)))
		else $error("input level taken from an unsettled sample");
	cover_change_c: cover property (@(posedge clk_in) disable iff (reset_in) level_reg != $past(level_reg));

endmodule // idm_debounce

// ===== verification/idm_switch_panel.sv
// Front-panel switch bank and indicator lamps facing the I/O mapper
module idm_switch_panel (
	input wire logic clk_in,
	input wire logic [7:0] closed_in,
	input wire logic [2:0] lamp_in,
	output logic [7:0] pins_out,
	output logic [2:0] lamp_lit_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pins_out = 8'h00;
	// Contacts follow the switches at the next rising clock edge, so edges land on the sampling edge
	always @(posedge clk_in) begin
		pins_out <= closed_in;
	end
	assign lamp_lit_out = lamp_in;
endmodule // idm_switch_panel

// ===== verification/drive_digital_io_mapper_tb.sv
// Self-checking bench for the digital I/O mapper with a front-panel model
module drive_digital_io_mapper_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import idm_pkg::*;
	// Short tick keeps the run small; the output and settle waits are derived from it
	localparam int SC = 16;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	idm_field_t idx = 16'h0000;
	idm_byte_t sub = 8'h00;
	idm_word_t wd = 32'h0;
	idm_word_t pv [3] = '{default: 32'h0};
	logic [7:0] sw = 8'h00;
	idm_word_t rdata;
	logic ack;
	logic err;
	idm_field_t src [3];
	logic [2:0] dout;
	logic [2:0] lamps;
	logic [7:0] pins;
	logic [7:0] hact;
	idm_byte_t stw;
	int mismatches = 0;
	int comparisons = 0;
	int cyc = 0;
	logic ok;
	idm_word_t r;
	idm_word_t dq;
	idm_word_t m [3];
	logic [2:0] inv;
	int n;
	int k;
	// ****
	// Tables: index, sub-index, value (and accept flag)
	// ****
	localparam logic [55:0] RST [17] = '{{16'h2C2C, 8'h01, 32'h608}, {16'h2C2C, 8'h02, 32'h80},
		{16'h2C2C, 8'h03, 32'h0}, {16'h2C2C, 8'h04, 32'h46C}, {16'h2C2C, 8'h05, 32'hD}, {16'h2C2C, 8'h06, 32'h0},
		{16'h2C2C, 8'h07, 32'h606}, {16'h2C2C, 8'h08, 32'h0}, {16'h2C2C, 8'h09, 32'h0}, {16'h2C2E, 8'h01, 32'h0},
		{16'h2C2E, 8'h02, 32'h1}, {16'h2C2E, 8'h03, 32'h0}, {16'h2C2E, 8'h19, 32'h0}, {16'h2C2E, 8'h04, 32'h0},
		{16'h2C2E, 8'h05, 32'h1}, {16'h2C2E, 8'h06, 32'h0}, {16'h2C2E, 8'h1A, 32'h0}};
	localparam logic [56:0] WT [8] = '{{16'h2C2E, 8'h05, 32'hFE, 1'b1}, {16'h2C2E, 8'h05, 32'hFF, 1'b0},
		{16'h2C2E, 8'h06, 32'h2, 1'b0}, {16'h2C2E, 8'h06, 32'h1, 1'b1}, {16'h2C2D, 8'h01, 32'h0, 1'b0},
		{16'h2C2F, 8'h01, 32'h0, 1'b0}, {16'h2C2C, 8'h0A, 32'h0, 1'b0}, {16'h2C2E, 8'h02, 32'hFF, 1'b0}};

	idm_io_mapper #(.SAMPLE_CYCLES(SC)) u_idm_io_mapper (.CLK_IN(clk), .RESET_IN(rst), .DIN_IN(pins),
		.OD_RD_IN(rd), .OD_WR_IN(wr), .OD_INDEX_IN(idx), .OD_SUB_IN(sub), .OD_WDATA_IN(wd),
		.OD_RDATA_OUT(rdata), .OD_ACK_OUT(ack), .OD_ERR_OUT(err), .PARAM1_VALUE_IN(pv[0]),
		.PARAM2_VALUE_IN(pv[1]), .PARAM3_VALUE_IN(pv[2]), .SRC1_FIELD_OUT(src[0]), .SRC2_FIELD_OUT(src[1]),
		.SRC3_FIELD_OUT(src[2]), .DOUT_OUT(dout), .HANDLER_ACTIVE_OUT(hact), .STATUS_WORD_OUT(stw));
	idm_switch_panel u_idm_switch_panel (.clk_in(clk), .closed_in(sw), .lamp_in(dout), .pins_out(pins),
		.lamp_lit_out(lamps));

	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			test_done();
		end
	end

	task automatic test_done();
		if (mismatches == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One strobe pulse, then a bounded wait for either answer
	task automatic od(input logic w, input idm_byte_t s, input idm_field_t i, input idm_word_t d,
		output logic a, output idm_word_t q);
		@(negedge clk);
		rd <= !w;
		wr <= w;
		idx <= i;
		sub <= s;
		wd <= d;
		@(negedge clk);
		rd <= 1'b0;
		wr <= 1'b0;
		repeat (3) begin
			if (ack === 1'b1 || err === 1'b1) break;
			@(negedge clk);
		end
		a = (ack === 1'b1);
		q = rdata;
	endtask

	function automatic logic expo(input idm_word_t p, input idm_word_t mk, input logic iv);
		return (|(p & mk)) ^ iv;
	endfunction

	initial begin
		void'($urandom(32'hE32FCF79));
		for (int j = 0; j < 3; j++) pv[j] = $urandom;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		chk("src fields", {src[0], src[1]}, 32'h0608046C);
		for (int i = 0; i < 17; i++) begin
			od(1'b0, RST[i][39:32], RST[i][55:40], 32'h0, ok, r);
			chk("reset value", r, RST[i][31:0]);
		end
		chk("default outputs", 32'(lamps), {29'h0, 1'b0, expo(pv[1], 32'hD, 1'b0), expo(pv[0], 32'h80, 1'b0)});
		for (int i = 0; i < 8; i++) begin
			od(1'b1, WT[i][40:33], WT[i][56:41], WT[i][32:1], ok, r);
			chk("accept", 32'(ok), 32'(WT[i][0]));
			chk("refuse", 32'(err), 32'(!WT[i][0]));
		end
		od(1'b0, 8'h05, 16'h2C2E, 32'h0, ok, r);
		chk("settle max", r, 32'hFE);
		od(1'b0, 8'h06, 16'h2C2E, 32'h0, ok, r);
		chk("flip", r, 32'h1);
		od(1'b0, 8'h02, 16'h2C2E, 32'h0, ok, r);
		chk("hwen settle", r, 32'h1);
		// Masks of zero and all ones as corners, then random mappings
		for (int it = 0; it < 12; it++) begin
			for (int j = 0; j < 3; j++) begin
				m[j] = (it == 0) ? 32'h0 : (it == 1) ? 32'hFFFFFFFF : $urandom;
				inv[j] = 1'($urandom);
				pv[j] = $urandom;
				if ($urandom % 3 == 0) pv[j] = pv[j] & ~m[j];
				r = $urandom;
				od(1'b1, 8'(3 * j + 1), 16'h2C2C, {16'h0, r[15:0]}, ok, dq);
				chk("field", 32'(src[j]), {16'h0, r[15:0]});
				od(1'b1, 8'(3 * j + 2), 16'h2C2C, m[j], ok, r);
				od(1'b1, 8'(3 * j + 3), 16'h2C2C, 32'(inv[j]), ok, r);
				od(1'b0, 8'(3 * j + 2), 16'h2C2C, 32'h0, ok, r);
				chk("mask", r, m[j]);
			end
			repeat (2 * SC + 3) @(negedge clk);
			for (int j = 0; j < 3; j++) chk("dout", 32'(lamps[j]), 32'(expo(pv[j], m[j], inv[j])));
		end
		// Each input rises then falls with a random settle count
		for (int t = 0; t < 16; t++) begin
			k = t % 8;
			n = 1 + $urandom % 4;
			inv[0] = 1'($urandom);
			od(1'b1, (k == 7) ? 8'h02 : 8'(3 * k + 5), 16'h2C2E, 32'(n), ok, r);
			od(1'b1, (k == 7) ? 8'h03 : 8'(3 * k + 6), 16'h2C2E, 32'(inv[0]), ok, r);
			sw[k] = ~sw[k];
			repeat ((n - 1) * SC) @(negedge clk);
			chk("early", 32'(stw[k]), 32'(!sw[k]));
			repeat (2 * SC + 6) @(negedge clk);
			chk("status", 32'(stw), 32'(sw));
			chk("handler", 32'(hact[k]), 32'(sw[k] ^ inv[0]));
			od(1'b0, 8'h01, 16'h2C2D, 32'h0, ok, r);
			chk("status read", r, 32'(sw));
		end
		test_done();
	end
endmodule // drive_digital_io_mapper_tb
